// ===== alsu_pkg.sv
// alsu_pkg: codes, widths, flag positions and timing of the unit.
// assumes: shared by the top module and its two helper modules.
package alsu_pkg;

  // ********************************************************
  // widths
  // ********************************************************
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;

  // ********************************************************
  // flag positions
  // ********************************************************
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_V = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_N = 3;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // ********************************************************
  // divider timing: one quotient bit per cycle
  // ********************************************************
  localparam int unsigned DIV_STEPS = 8;

  // ********************************************************
  // operation codes
  // ********************************************************
  typedef enum logic [4:0] {
    OP_ADD                          = 5'h00,
    OP_SUB                          = 5'h01,
    OP_ADD_WITH_CARRY               = 5'h02,
    OP_SUBTRACT_WITH_BORROW         = 5'h03,
    OP_PLUS_ONE_BYTE                = 5'h04,
    OP_MINUS_ONE_BYTE               = 5'h05,
    OP_WORD_SMALL_IMMEDIATE_ADD     = 5'h06,
    OP_WORD_SMALL_IMMEDIATE_SUBTRACT = 5'h07,
    OP_DECIMAL_FIX_AFTER_ADD        = 5'h08,
    OP_DECIMAL_FIX_AFTER_SUBTRACT   = 5'h09,
    OP_UNSIGNED_MULTIPLY            = 5'h0a,
    OP_UNSIGNED_DIVIDE              = 5'h0b,
    OP_COMPARE                      = 5'h0c,
    OP_NEGATE                       = 5'h0d,
    OP_AND                          = 5'h0e,
    OP_OR                           = 5'h0f,
    OP_XOR                          = 5'h10,
    OP_NOT                          = 5'h11,
    OP_ARITH_LEFT_SHIFT             = 5'h12,
    OP_ARITH_RIGHT_SHIFT            = 5'h13,
    OP_LOGICAL_LEFT_SHIFT           = 5'h14,
    OP_LOGICAL_RIGHT_SHIFT          = 5'h15,
    OP_CIRCULAR_LEFT                = 5'h16,
    OP_CIRCULAR_RIGHT               = 5'h17,
    OP_CARRY_CIRCULAR_LEFT          = 5'h18,
    OP_CARRY_CIRCULAR_RIGHT         = 5'h19
  } alsu_op_t;

  // ********************************************************
  // unit states, one-hot
  // ********************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_DIV  = 2'h2
  } alsu_state_t;

endpackage : alsu_pkg

// ===== alsu_addsub.sv
// alsu_addsub: adder with carry in, invert and byte/word flags.
// assumes: combinational, used for every sum except the decimal fix and the divider steps.
`timescale 1ns/1ps
`default_nettype none
module alsu_addsub
  import alsu_pkg::*;
(
  // operands
  input  wire logic [WORD_W-1:0] a_in,
  input  wire logic [WORD_W-1:0] b_in,
  input  wire logic              sub_in,
  input  wire logic              cin_in,
  input  wire logic              word_in,
  // result
  output logic      [WORD_W-1:0] sum_out,
  output logic      [3:0]        flags_out
);
  logic [WORD_W-1:0] b_x;
  logic [WORD_W:0]   full;
  logic [BYTE_W:0]   low;
  logic              cin_x;

  always_comb begin
    b_x   = sub_in ? ~b_in : b_in;
    cin_x = sub_in ? ~cin_in : cin_in;
    full  = {1'b0, a_in} + {1'b0, b_x} + {{WORD_W{1'b0}}, cin_x};
    low   = {1'b0, a_in[BYTE_W-1:0]} + {1'b0, b_x[BYTE_W-1:0]}
          + {{BYTE_W{1'b0}}, cin_x};
    sum_out = full[WORD_W-1:0];
    flags_out = 4'h0;
    if (word_in) begin
      flags_out[FLG_C] = full[WORD_W] ^ sub_in;
      flags_out[FLG_V] = (a_in[WORD_W-1] == b_x[WORD_W-1])
                       && (full[WORD_W-1] != a_in[WORD_W-1]);
      flags_out[FLG_Z] = (full[WORD_W-1:0] == 16'h0000);
      flags_out[FLG_N] = full[WORD_W-1];
    end else begin
      flags_out[FLG_C] = low[BYTE_W] ^ sub_in;
      flags_out[FLG_V] = (a_in[BYTE_W-1] == b_x[BYTE_W-1])
                       && (low[BYTE_W-1] != a_in[BYTE_W-1]);
      flags_out[FLG_Z] = (low[BYTE_W-1:0] == 8'h00);
      flags_out[FLG_N] = low[BYTE_W-1];
    end
  end
endmodule : alsu_addsub
`default_nettype wire

// ===== alsu_shifter.sv
// alsu_shifter: one-bit byte shifts and rotates with carry out.
// assumes: combinational; op_in picks a shift code.
`timescale 1ns/1ps
`default_nettype none
module alsu_shifter
  import alsu_pkg::*;
(
  // operand
  input  wire logic [BYTE_W-1:0] d_in,
  input  wire logic              cin_in,
  input  wire alsu_op_t          op_in,
  // result
  output logic      [BYTE_W-1:0] q_out,
  output logic                   cout_out
);
  always_comb begin
    case (op_in)
      OP_ARITH_LEFT_SHIFT, OP_LOGICAL_LEFT_SHIFT: begin
        q_out    = {d_in[6:0], 1'b0};
        cout_out = d_in[7];
      end
      OP_ARITH_RIGHT_SHIFT: begin
        q_out    = {d_in[7], d_in[7:1]};
        cout_out = d_in[0];
      end
      OP_LOGICAL_RIGHT_SHIFT: begin
        q_out    = {1'b0, d_in[7:1]};
        cout_out = d_in[0];
      end
      OP_CIRCULAR_LEFT: begin
        q_out    = {d_in[6:0], d_in[7]};
        cout_out = d_in[7];
      end
      OP_CIRCULAR_RIGHT: begin
        q_out    = {d_in[0], d_in[7:1]};
        cout_out = d_in[0];
      end
      OP_CARRY_CIRCULAR_LEFT: begin
        q_out    = {d_in[6:0], cin_in};
        cout_out = d_in[7];
      end
      OP_CARRY_CIRCULAR_RIGHT: begin
        q_out    = {cin_in, d_in[7:1]};
        cout_out = d_in[0];
      end
      default: begin
        q_out    = d_in;
        cout_out = 1'b0;
      end
    endcase
  end
endmodule : alsu_shifter
`default_nettype wire

// ===== alsu_unit.sv
// alsu_unit: arithmetic, logic and shift execution unit of the cpu core.
// assumes: decoder sends one-cycle start pulses on mclk_in;
// register file takes the result on done_out.
//
// Function
// - add and subtract on byte or word registers; add also takes an immediate
// - word add or subtract only with both operands from registers
// - carry add and borrow subtract: bytes only, carry included, register or immediate
// - plus one and minus one on a byte register, written back
// - word small immediate add or subtract accepts only one or two
// - decimal fix after add or subtract corrects a byte using the flags
// - unsigned multiply of two bytes gives a 16-bit product
// - unsigned divide 16 by 8 gives quotient and remainder bytes
// - compare subtracts and updates flags only, operands unchanged
// - word compare only between registers; immediate only for bytes
// - negate replaces a byte with zero minus it
// - and, or, xor combine a byte with register or immediate byte
// - not inverts every bit of a byte register
// - arithmetic shifts by one bit; right shift keeps the sign
// - logical shifts by one bit, vacated bit filled with zero
// - plain rotates by one bit, out bit fed to the other end
// - carry rotates by one bit with carry as ninth bit
// - condition flags hold negative, zero, overflow and carry
`timescale 1ns/1ps
`default_nettype none
module alsu_unit
  import alsu_pkg::*;
(
  // clock, reset, enable
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  input  wire logic              ce_in,
  // request from decoder
  input  wire logic              start_in,
  input  wire alsu_op_t          op_in,
  input  wire logic              word_in,
  input  wire logic              imm_in,
  input  wire logic [WORD_W-1:0] dst_in,
  input  wire logic [WORD_W-1:0] src_in,
  // condition flags load from the cpu
  input  wire logic              flags_load_in,
  input  wire logic [3:0]        flags_load_val_in,
  // answer to register file
  output logic                   done_out,
  output logic                   busy_out,
  output logic                   write_out,
  output logic                   illegal_out,
  output logic      [WORD_W-1:0] result_out,
  output logic      [3:0]        flags_out
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    alsu_state_t       st;
    logic [3:0]        cnt;
    logic [WORD_W-1:0] rem;
    logic [BYTE_W-1:0] dvs;
    logic [BYTE_W-1:0] quo;
    logic              done;
    logic              write;
    logic              illegal;
    logic [WORD_W-1:0] res;
    logic [3:0]        flags;
  } alsu_regs_t;

  alsu_regs_t r_q;
  alsu_regs_t r_d;

  // ********************************************************
  // shared adder and shifter
  // ********************************************************
  logic [WORD_W-1:0] add_a;
  logic [WORD_W-1:0] add_b;
  logic              add_sub;
  logic              add_cin;
  logic              add_word;
  logic [WORD_W-1:0] add_sum;
  logic [3:0]        add_flags;
  logic [BYTE_W-1:0] sh_q;
  logic              sh_cout;

  alsu_addsub u_addsub (
    .a_in      (add_a),
    .b_in      (add_b),
    .sub_in    (add_sub),
    .cin_in    (add_cin),
    .word_in   (add_word),
    .sum_out   (add_sum),
    .flags_out (add_flags)
  );

  alsu_shifter u_shifter (
    .d_in     (dst_in[BYTE_W-1:0]),
    .cin_in   (r_q.flags[FLG_C]),
    .op_in    (op_in),
    .q_out    (sh_q),
    .cout_out (sh_cout)
  );

  // ********************************************************
  // operation logic
  // ********************************************************
  logic [BYTE_W-1:0] b8;
  logic [BYTE_W-1:0] lg;
  logic [BYTE_W-1:0] fix;
  logic              fix_c;
  logic [WORD_W:0]   trial;
  logic [WORD_W-1:0] prod;

  always_comb begin
    r_d      = r_q;
    b8       = src_in[BYTE_W-1:0];
    lg       = 8'h00;
    fix      = 8'h00;
    fix_c    = 1'b0;
    trial    = {(WORD_W+1){1'b0}};
    prod     = {8'h00, dst_in[BYTE_W-1:0]} * {8'h00, src_in[BYTE_W-1:0]};
    add_a    = dst_in;
    add_b    = src_in;
    add_sub  = 1'b0;
    add_cin  = 1'b0;
    add_word = 1'b0;
    r_d.done = 1'b0;
    r_d.write = 1'b0;
    r_d.illegal = 1'b0;
    case (op_in)
      OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_MINUS_ONE_BYTE,
      OP_WORD_SMALL_IMMEDIATE_SUBTRACT, OP_COMPARE, OP_NEGATE: add_sub = 1'b1;
      default: add_sub = 1'b0;
    endcase
    case (op_in)
      OP_ADD, OP_SUB, OP_COMPARE: add_word = word_in;
      OP_WORD_SMALL_IMMEDIATE_ADD, OP_WORD_SMALL_IMMEDIATE_SUBTRACT: add_word = 1'b1;
      default: add_word = 1'b0;
    endcase
    case (op_in)
      OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: add_cin = r_q.flags[FLG_C];
      default: add_cin = 1'b0;
    endcase
    case (op_in)
      OP_PLUS_ONE_BYTE, OP_MINUS_ONE_BYTE: add_b = 16'h0001;
      OP_NEGATE: begin
        add_a = 16'h0000;
        add_b = dst_in;
      end
      default: add_b = src_in;
    endcase
    if (r_q.st == ST_DIV) begin
      trial = {r_q.rem, 1'b0} - {1'b0, r_q.dvs, 8'h00};
    end
    case (r_q.st)
      ST_IDLE: begin
        if (start_in) begin
          r_d.done    = 1'b1;
          r_d.write   = 1'b1;
          r_d.illegal = 1'b0;
          r_d.res     = {8'h00, add_sum[BYTE_W-1:0]};
          case (op_in)
            OP_ADD, OP_SUB: begin
              if ((op_in == OP_SUB || word_in) && imm_in) begin
                r_d.illegal = 1'b1;
                r_d.write   = 1'b0;
              end else begin
                r_d.res   = word_in ? add_sum : {dst_in[15:8], add_sum[7:0]};
                r_d.flags = add_flags;
              end
            end
            OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_PLUS_ONE_BYTE,
            OP_MINUS_ONE_BYTE, OP_NEGATE: begin
              r_d.res   = {dst_in[15:8], add_sum[7:0]};
              r_d.flags = add_flags;
              if (op_in == OP_ADD_WITH_CARRY || op_in == OP_SUBTRACT_WITH_BORROW) begin
                r_d.flags[FLG_Z] = add_flags[FLG_Z] & r_q.flags[FLG_Z];
              end
              if (op_in == OP_PLUS_ONE_BYTE || op_in == OP_MINUS_ONE_BYTE) begin
                r_d.flags[FLG_C] = r_q.flags[FLG_C];
              end
            end
            OP_WORD_SMALL_IMMEDIATE_ADD, OP_WORD_SMALL_IMMEDIATE_SUBTRACT: begin
              if (src_in == 16'h0001 || src_in == 16'h0002) begin
                r_d.res = add_sum;
              end else begin
                r_d.illegal = 1'b1;
                r_d.write   = 1'b0;
              end
            end
            OP_DECIMAL_FIX_AFTER_ADD, OP_DECIMAL_FIX_AFTER_SUBTRACT: begin
              fix_c = r_q.flags[FLG_C] || (op_in == OP_DECIMAL_FIX_AFTER_ADD
                      && dst_in[7:0] > 8'h99);
              if (fix_c) begin
                fix[7:4] = 4'h6;
              end
              if (dst_in[3:0] > 4'h9 && op_in == OP_DECIMAL_FIX_AFTER_ADD) begin
                fix[3:0] = 4'h6;
              end
              if (op_in == OP_DECIMAL_FIX_AFTER_ADD) begin
                lg = dst_in[7:0] + fix;
              end else begin
                lg = dst_in[7:0] - fix;
              end
              r_d.res          = {dst_in[15:8], lg};
              r_d.flags[FLG_C] = fix_c;
              r_d.flags[FLG_N] = lg[7];
              r_d.flags[FLG_Z] = (lg == 8'h00);
            end
            OP_UNSIGNED_MULTIPLY: begin
              r_d.res = prod;
            end
            OP_UNSIGNED_DIVIDE: begin
              r_d.done  = 1'b0;
              r_d.write = 1'b0;
              r_d.st    = ST_DIV;
              r_d.cnt   = 4'(DIV_STEPS);
              r_d.rem   = dst_in;
              r_d.dvs   = b8;
              r_d.quo   = 8'h00;
            end
            OP_COMPARE: begin
              r_d.write = 1'b0;
              if (word_in && imm_in) begin
                r_d.illegal = 1'b1;
              end else begin
                r_d.flags = add_flags;
              end
            end
            OP_AND, OP_OR, OP_XOR, OP_NOT: begin
              case (op_in)
                OP_AND:  lg = dst_in[7:0] & b8;
                OP_OR:   lg = dst_in[7:0] | b8;
                OP_XOR:  lg = dst_in[7:0] ^ b8;
                default: lg = ~dst_in[7:0];
              endcase
              r_d.res          = {dst_in[15:8], lg};
              r_d.flags[FLG_V] = 1'b0;
              r_d.flags[FLG_N] = lg[7];
              r_d.flags[FLG_Z] = (lg == 8'h00);
            end
            OP_ARITH_LEFT_SHIFT, OP_ARITH_RIGHT_SHIFT, OP_LOGICAL_LEFT_SHIFT,
            OP_LOGICAL_RIGHT_SHIFT, OP_CIRCULAR_LEFT, OP_CIRCULAR_RIGHT,
            OP_CARRY_CIRCULAR_LEFT, OP_CARRY_CIRCULAR_RIGHT: begin
              r_d.res          = {dst_in[15:8], sh_q};
              r_d.flags[FLG_C] = sh_cout;
              r_d.flags[FLG_V] = 1'b0;
              r_d.flags[FLG_N] = sh_q[7];
              r_d.flags[FLG_Z] = (sh_q == 8'h00);
            end
            default: begin
              r_d.illegal = 1'b1;
              r_d.write   = 1'b0;
            end
          endcase
        end else if (flags_load_in) begin
          r_d.flags = flags_load_val_in;
        end
      end
      ST_DIV: begin
        if (!trial[WORD_W]) begin
          r_d.rem = trial[WORD_W-1:0];
        end else begin
          r_d.rem = {r_q.rem[WORD_W-2:0], 1'b0};
        end
        r_d.quo = {r_q.quo[6:0], ~trial[WORD_W]};
        r_d.cnt = r_q.cnt - 4'h1;
        if (r_q.cnt == 4'h1) begin
          r_d.st           = ST_IDLE;
          r_d.done         = 1'b1;
          r_d.write        = (r_q.dvs != 8'h00);
          r_d.res          = {r_d.rem[15:8], r_d.quo};
          r_d.flags[FLG_Z] = (r_q.dvs == 8'h00);
          r_d.flags[FLG_N] = r_d.quo[7];
        end
      end
      default: r_d.st = ST_IDLE;
    endcase
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_q       <= '0;
      r_q.st    <= ST_IDLE;
      r_q.flags <= FLAGS_RST;
    end else if (ce_in) begin
      r_q <= r_d;
    end
  end

  always_comb begin
    done_out    = r_q.done;
    busy_out    = r_q.st[1];
    write_out   = r_q.write;
    illegal_out = r_q.illegal;
    result_out  = r_q.res;
    flags_out   = r_q.flags;
  end

endmodule : alsu_unit
`default_nettype wire

// ===== alsu_unit_monitor.sv
// alsu_unit_monitor: port-level checks of the execution unit.
// assumes: bound to alsu_unit.
`timescale 1ns/1ps
`default_nettype none
module alsu_unit_monitor
  import alsu_pkg::*;
(
  // clock, reset, enable
  input wire logic              mclk_in,
  input wire logic              rst_b_in,
  input wire logic              ce_in,
  // request
  input wire logic              start_in,
  input wire alsu_op_t          op_in,
  input wire logic              word_in,
  input wire logic              imm_in,
  input wire logic [WORD_W-1:0] dst_in,
  input wire logic [WORD_W-1:0] src_in,
  // answer
  input wire logic              done_out,
  input wire logic              busy_out,
  input wire logic              write_out,
  input wire logic              illegal_out,
  input wire logic [WORD_W-1:0] result_out,
  input wire logic [3:0]        flags_out
);
  logic              take;
  logic [WORD_W-1:0] mul_exp;
  logic [BYTE_W-1:0] not_exp;
  assign take    = ce_in && start_in && !busy_out;
  assign mul_exp = dst_in[7:0] * src_in[7:0];
  assign not_exp = ~dst_in[7:0];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // ********************************************************
  // assertions
  // ********************************************************
  chk_single_done: assert property (take && op_in != OP_UNSIGNED_DIVIDE |=> done_out)
    else $error("done missing");
  chk_div_timing: assert property (take && op_in == OP_UNSIGNED_DIVIDE && src_in[7:0] != 8'h00
    |=> busy_out [*8] ##1 (done_out && !busy_out))
    else $error("divide timing");
  chk_done_qual: assert property ((write_out || illegal_out) |-> done_out && !(write_out && illegal_out))
    else $error("stray write or illegal");
  chk_sub_imm: assert property (take && op_in == OP_SUB && imm_in |=> illegal_out && !write_out)
    else $error("sub immediate taken");
  chk_word_imm: assert property (take && word_in && imm_in && (op_in == OP_ADD || op_in == OP_COMPARE)
    |=> illegal_out)
    else $error("word immediate taken");
  chk_small_imm: assert property (take && (op_in == OP_WORD_SMALL_IMMEDIATE_ADD ||
    op_in == OP_WORD_SMALL_IMMEDIATE_SUBTRACT) && src_in != 16'h0001 && src_in != 16'h0002
    |=> illegal_out)
    else $error("bad small immediate");
  chk_cmp_nowrite: assert property (take && op_in == OP_COMPARE |=> done_out && !write_out)
    else $error("compare wrote");
  chk_mul_prod: assert property (take && op_in == OP_UNSIGNED_MULTIPLY
    |=> write_out && result_out == $past(mul_exp))
    else $error("product wrong");
  chk_not_inv: assert property (take && op_in == OP_NOT |=> result_out[7:0] == $past(not_exp))
    else $error("complement wrong");
  chk_illegal_keep: assert property (illegal_out |-> $stable(flags_out))
    else $error("refusal moved flags");
  // ********************************************************
  // covers
  // ********************************************************
  cov_divide: cover property (take && op_in == OP_UNSIGNED_DIVIDE);
  cov_illegal: cover property (illegal_out);
  cov_carry: cover property (done_out && write_out && flags_out[FLG_C]);
endmodule : alsu_unit_monitor
bind alsu_unit alsu_unit_monitor u_mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
  .start_in(start_in), .op_in(op_in), .word_in(word_in), .imm_in(imm_in), .dst_in(dst_in),
  .src_in(src_in), .done_out(done_out), .busy_out(busy_out), .write_out(write_out),
  .illegal_out(illegal_out), .result_out(result_out), .flags_out(flags_out));
`default_nettype wire

// ===== alsu_dec_model.sv
// alsu_dec_model: decoder and register file side.
// assumes: drives at the falling edge of mclk_in.
`timescale 1ns/1ps
`default_nettype none
module alsu_dec_model
  import alsu_pkg::*;
(
  // clock
  input  wire logic              mclk_in,
  // request
  output logic                   start_out,
  output alsu_op_t               op_out,
  output logic                   word_out,
  output logic                   imm_out,
  output logic      [WORD_W-1:0] dst_out,
  output logic      [WORD_W-1:0] src_out,
  output logic                   fload_out,
  output logic      [3:0]        fval_out,
  // answer
  input  wire logic              done_in,
  input  wire logic              write_in,
  input  wire logic              illegal_in,
  input  wire logic [WORD_W-1:0] result_in,
  input  wire logic [3:0]        flags_in
);
  initial begin
    start_out = 1'b0;
    op_out    = OP_ADD;
    word_out  = 1'b0;
    imm_out   = 1'b0;
    dst_out   = 16'h0000;
    src_out   = 16'h0000;
    fload_out = 1'b0;
    fval_out  = 4'h0;
  end
  task automatic send(input alsu_op_t op, input logic w, i, input logic [15:0] d, s);
    @(negedge mclk_in);
    start_out = 1'b1;
    op_out    = op;
    word_out  = w;
    imm_out   = i;
    dst_out   = d;
    src_out   = s;
    @(negedge mclk_in);
    start_out = 1'b0;
    dst_out   = ~d;
    src_out   = ~s;
  endtask : send
  task automatic wait_done(output int n, output logic w, il, output logic [15:0] r,
                           output logic [3:0] f);
    n = 1;
    while (done_in !== 1'b1 && n < 40) begin
      @(negedge mclk_in);
      n++;
    end
    w  = write_in;
    il = illegal_in;
    r  = result_in;
    f  = flags_in;
  endtask : wait_done
  task automatic load_flags(input logic [3:0] v);
    @(negedge mclk_in);
    fload_out = 1'b1;
    fval_out  = v;
    @(negedge mclk_in);
    fload_out = 1'b0;
    fval_out  = ~v;
  endtask : load_flags
endmodule : alsu_dec_model
`default_nettype wire

// ===== test_cpu_arith_logic_shift_unit.sv
// test_cpu_arith_logic_shift_unit: self-checking bench.
// assumes: alsu_dec_model plays the decoder.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_arith_logic_shift_unit;
  import alsu_pkg::*;
  logic mclk_in, rst_b_in, ce_in;
  logic start, word, imm, fload, done, busy, wr, ill;
  alsu_op_t op;
  logic [15:0] dst, src, res;
  logic [3:0]  fval, flg;
  int failures = 0;
  int checked  = 0;
  int cycles   = 0;
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  alsu_unit u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .start_in(start),
    .op_in(op), .word_in(word), .imm_in(imm), .dst_in(dst), .src_in(src),
    .flags_load_in(fload), .flags_load_val_in(fval), .done_out(done), .busy_out(busy),
    .write_out(wr), .illegal_out(ill), .result_out(res), .flags_out(flg));
  alsu_dec_model u_dec (.mclk_in(mclk_in), .start_out(start), .op_out(op), .word_out(word),
    .imm_out(imm), .dst_out(dst), .src_out(src), .fload_out(fload), .fval_out(fval),
    .done_in(done), .write_in(wr), .illegal_in(ill), .result_in(res), .flags_in(flg));
  task automatic conclude;
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task automatic cmp(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // one request and its checks
  task automatic run(input alsu_op_t o, input logic w, i, input logic [15:0] d, s,
                     input logic ew, ei, input logic [15:0] er, input logic [3:0] ef, fm,
                     input int ec);
    int n;
    logic gw, gi;
    logic [15:0] gr;
    logic [3:0] gf;
    u_dec.send(o, w, i, d, s);
    u_dec.wait_done(n, gw, gi, gr, gf);
    cmp("write", 16'(ew), 16'(gw));
    cmp("illegal", 16'(ei), 16'(gi));
    if (ew) cmp("result", er, gr);
    cmp("flags", 16'(ef & fm), 16'(gf & fm));
    if (ec > 0) cmp("cycles", 16'(ec), 16'(n));
  endtask : run
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset;
    cmp("reset result", 16'h0000, res);
    cmp("reset flags", 16'h0000, 16'(flg));
    cmp("reset busy", 16'h0000, 16'(busy));
  endtask : t_reset
  task automatic t_freeze;
    ce_in = 1'b0;
    u_dec.load_flags(4'hf);
    ce_in = 1'b1;
    cmp("frozen flags", 16'h0001, 16'(flg));
  endtask : t_freeze
  task automatic t_addsub;
    run(OP_ADD, 0, 0, 16'h5a7f, 16'h0001, 1, 0, 16'h5a80, 4'ha, 4'hf, 1);
    run(OP_ADD, 1, 0, 16'hffff, 16'h0001, 1, 0, 16'h0000, 4'h5, 4'hf, 1);
    run(OP_ADD, 0, 1, 16'h0010, 16'h0022, 1, 0, 16'h0032, 4'h0, 4'hf, 1);
    run(OP_SUB, 1, 0, 16'h1000, 16'h0001, 1, 0, 16'h0fff, 4'h0, 4'hf, 1);
    run(OP_SUB, 0, 0, 16'h0000, 16'h0001, 1, 0, 16'h00ff, 4'h9, 4'hf, 1);
  endtask : t_addsub
  task automatic t_refuse;
    u_dec.load_flags(4'h5);
    run(OP_SUB, 0, 1, 16'h0005, 16'h0001, 0, 1, 16'h0, 4'h5, 4'hf, 1);
    run(OP_ADD, 1, 1, 16'h0005, 16'h0001, 0, 1, 16'h0, 4'h5, 4'hf, 1);
    run(OP_COMPARE, 1, 1, 16'h0005, 16'h0001, 0, 1, 16'h0, 4'h5, 4'hf, 1);
    run(OP_WORD_SMALL_IMMEDIATE_ADD, 1, 1, 16'h0005, 16'h0003, 0, 1, 16'h0, 4'h5, 4'hf, 1);
    run(alsu_op_t'(5'h1f), 0, 0, 16'h0005, 16'h0001, 0, 1, 16'h0, 4'h5, 4'hf, 1);
  endtask : t_refuse
  task automatic t_carry;
    u_dec.load_flags(4'h1);
    run(OP_ADD_WITH_CARRY, 0, 0, 16'h0010, 16'h0020, 1, 0, 16'h0031, 4'h0, 4'hf, 1);
    u_dec.load_flags(4'h5);
    run(OP_SUBTRACT_WITH_BORROW, 0, 1, 16'h0001, 16'h0000, 1, 0, 16'h0000, 4'h4, 4'hf, 1);
  endtask : t_carry
  task automatic t_incdec;
    u_dec.load_flags(4'h1);
    run(OP_PLUS_ONE_BYTE, 0, 0, 16'h00ff, 16'h0, 1, 0, 16'h0000, 4'h5, 4'hf, 1);
    run(OP_MINUS_ONE_BYTE, 0, 0, 16'h0080, 16'h0, 1, 0, 16'h007f, 4'h3, 4'hf, 1);
    run(OP_WORD_SMALL_IMMEDIATE_ADD, 1, 1, 16'hfffe, 16'h2, 1, 0, 16'h0000, 4'h0, 4'h0, 1);
    run(OP_WORD_SMALL_IMMEDIATE_SUBTRACT, 1, 1, 16'h0, 16'h1, 1, 0, 16'hffff, 4'h0, 4'h0, 1);
  endtask : t_incdec
  task automatic t_decimal;
    run(OP_ADD, 0, 0, 16'h0015, 16'h0027, 1, 0, 16'h003c, 4'h0, 4'hf, 1);
    run(OP_DECIMAL_FIX_AFTER_ADD, 0, 0, 16'h003c, 16'h0, 1, 0, 16'h0042, 4'h0, 4'h0, 1);
    run(OP_SUB, 0, 0, 16'h0010, 16'h0020, 1, 0, 16'h00f0, 4'h9, 4'hf, 1);
    run(OP_DECIMAL_FIX_AFTER_SUBTRACT, 0, 0, 16'h00f0, 16'h0, 1, 0, 16'h0090, 4'h0, 4'h0, 1);
  endtask : t_decimal
  task automatic t_muldiv;
    int n;
    logic gw, gi;
    logic [15:0] gr;
    logic [3:0] gf;
    run(OP_UNSIGNED_MULTIPLY, 0, 0, 16'h00ff, 16'h00ff, 1, 0, 16'hfe01, 4'h0, 4'h0, 1);
    run(OP_UNSIGNED_DIVIDE, 0, 0, 16'h1234, 16'h0056, 1, 0, 16'h1036, 4'h0, 4'h0, 9);
    u_dec.send(OP_UNSIGNED_DIVIDE, 0, 0, 16'h1234, 16'h0056);
    u_dec.send(OP_NOT, 0, 0, 16'h000f, 16'h0);
    u_dec.wait_done(n, gw, gi, gr, gf);
    cmp("busy cycles", 16'd7, 16'(n));
    cmp("busy result", 16'h1036, gr);
    run(OP_UNSIGNED_DIVIDE, 0, 0, 16'h1234, 16'h0000, 0, 0, 16'h0, 4'h4, 4'h4, 0);
  endtask : t_muldiv
  task automatic t_cmpneg;
    run(OP_COMPARE, 1, 0, 16'h1000, 16'h2000, 0, 0, 16'h0, 4'h9, 4'hf, 1);
    run(OP_COMPARE, 0, 1, 16'h0005, 16'h0005, 0, 0, 16'h0, 4'h4, 4'hf, 1);
    run(OP_NEGATE, 0, 0, 16'h0080, 16'h0, 1, 0, 16'h0080, 4'hb, 4'hf, 1);
    run(OP_NEGATE, 0, 0, 16'h0001, 16'h0, 1, 0, 16'h00ff, 4'h9, 4'hf, 1);
  endtask : t_cmpneg
  task automatic t_logic;
    u_dec.load_flags(4'h2);
    run(OP_AND, 0, 0, 16'h00f0, 16'h003c, 1, 0, 16'h0030, 4'h0, 4'he, 1);
    run(OP_OR, 0, 1, 16'h000f, 16'h0080, 1, 0, 16'h008f, 4'h8, 4'he, 1);
    run(OP_XOR, 0, 0, 16'h00aa, 16'h00aa, 1, 0, 16'h0000, 4'h4, 4'he, 1);
    u_dec.load_flags(4'h2);
    run(OP_NOT, 0, 0, 16'h000f, 16'h0, 1, 0, 16'h00f0, 4'h8, 4'he, 1);
  endtask : t_logic
  task automatic t_shift;
    alsu_op_t ops [8] = '{OP_ARITH_LEFT_SHIFT, OP_ARITH_RIGHT_SHIFT, OP_LOGICAL_LEFT_SHIFT,
      OP_LOGICAL_RIGHT_SHIFT, OP_CIRCULAR_LEFT, OP_CIRCULAR_RIGHT, OP_CARRY_CIRCULAR_LEFT,
      OP_CARRY_CIRCULAR_RIGHT};
    logic [7:0] rs [8] = '{8'h02, 8'hc0, 8'h02, 8'h40, 8'h03, 8'hc0, 8'h02, 8'h40};
    logic [3:0] fs [8] = '{4'h1, 4'h9, 4'h1, 4'h1, 4'h1, 4'h9, 4'h1, 4'h1};
    for (int k = 0; k < 8; k++) begin
      u_dec.load_flags(4'h2);
      run(ops[k], 0, 0, 16'h0081, 16'h0, 1, 0, {8'h00, rs[k]}, fs[k], 4'hf, 1);
    end
  endtask : t_shift
  initial begin
    rst_b_in = 1'b0;
    ce_in    = 1'b1;
    repeat (16) @(negedge mclk_in);
    rst_b_in = 1'b1;
    t_reset();
    t_addsub();
    t_refuse();
    t_carry();
    t_incdec();
    t_decimal();
    t_muldiv();
    t_cmpneg();
    t_logic();
    t_shift();
    t_freeze();
    conclude();
  end
endmodule : test_cpu_arith_logic_shift_unit
`default_nettype wire
